// ---- include/fault_consts.svh ----
/*
 Constants for the two-channel LED string fault monitor: status bit positions,
 reset values and synchroniser depth. Assumes one 50 MHz clock, no bus.
*/
// Overview of operation
// [RL1] Overvoltage halts switching, opens the disconnect switch
// [RL2] Overvoltage sets status bit 4 or 0
// [RL3] Alert asserts with the overvoltage status bit
// [RL4] Open string: feedback high, sense current low
// [RL5] Open string sets bit 5 or 1, alerts
// [RL6] Shorted string: feedback below short threshold
// [RL7] Disconnect switch follows dimming; open means no current
// [RL8] Fault bits latch until the host clears them
// [RL9] Alert only for enabled faults; enables reset high
// [RL10] Alert is open drain, pulled up, active low
// [RL11] Two independent channels share status and alert
`ifndef FAULT_CONSTS_SVH
`define FAULT_CONSTS_SVH

`define STATUS_WIDTH 8
`define CH1_FEEDBACK_OVERVOLTAGE_FAULT_BIT 4
`define CH2_FEEDBACK_OVERVOLTAGE_FAULT_BIT 0
`define CH1_OPEN_BIT 5
`define CH2_OPEN_BIT 1
`define CH1_SHORT_BIT 6
`define CH2_SHORT_BIT 2
`define STATUS_RESET 8'h00
`define ENABLE_RESET 8'hFF
`define SYNC_STAGES 3

`endif

// ---- include/fault_pkg.sv ----
/*
 Types shared by the fault monitor and its channel units.
 Assumes fault_consts.svh is available on the include path.
*/
package fault_pkg;
  typedef enum logic [1:0] {
    CH_OFF = 2'b00,
    CH_RUN = 2'b01,
    CH_HALT = 2'b10
  } chan_state_t;
  typedef logic [7:0] status_t;
endpackage

// ---- hw/channel_fault_unit.sv ----
/*
 One channel: synchronises its comparator pins, raises fault levels and
 steers switching and the disconnect switch. Assumes halt comes from the
 shared latched status, on the same clock.
*/
`timescale 1ns/10ps
module channel_fault_unit (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Comparator pins, asynchronous
  input wire logic feedback_overvoltage_fault_cmp,
  input wire logic fb_near_reg_cmp,
  input wire logic sense_low_cmp,
  input wire logic fb_short_cmp,
  // Control
  input wire logic channel_enable,
  input wire logic dim_on,
  input wire logic halt_latched,
  // Fault levels
  output logic ov_fault,
  output logic open_fault,
  output logic short_fault,
  // Power stage
  output logic switch_run,
  output logic disconnect_gate_drive
);
  import fault_pkg::*;
  `include "fault_consts.svh"

  localparam int N = 4;
  logic [N-1:0] pins;
  logic [N-1:0] s1_r, s2_r, s3_r, level_r;
  chan_state_t state_r, state_nxt;
  logic gate_r, run_r;

  assign pins = {fb_short_cmp, sense_low_cmp, fb_near_reg_cmp, feedback_overvoltage_fault_cmp};

  // Three stages; a level only moves when stages two and three agree
  always_ff @(posedge clk) begin
    if (rst) begin
      s1_r <= '0;
      s2_r <= '0;
      s3_r <= '0;
      level_r <= '0;
    end else begin
      s1_r <= pins;
      s2_r <= s1_r;
      s3_r <= s2_r;
      for (int i = 0; i < N; i++) begin
        if (s2_r[i] == s3_r[i]) begin
          level_r[i] <= s3_r[i];
        end
      end
    end
  end

  assign ov_fault = level_r[0];
  assign open_fault = level_r[1] & level_r[2]; // see [RL4]
  // Short only counts while the stage runs, so a stopped output is no short
  assign short_fault = level_r[3] & (state_r == CH_RUN); // see [RL6]

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      CH_OFF: begin
        if (channel_enable && !halt_latched && !ov_fault) begin
          state_nxt = CH_RUN;
        end
      end
      CH_RUN: begin
        if (ov_fault || short_fault) begin
          state_nxt = CH_HALT; // see [RL1]
        end else if (!channel_enable) begin
          state_nxt = CH_OFF;
        end
      end
      CH_HALT: begin
        // Stays stopped until the host clears the latched bit
        if (!halt_latched && !ov_fault) begin
          state_nxt = CH_OFF;
        end
      end
      default: state_nxt = CH_OFF;
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state_r <= CH_OFF;
    end else begin
      state_r <= state_nxt;
    end
  end

  // Outputs follow the next state, so a trip stops them at the same edge
  always_ff @(posedge clk) begin
    if (rst) begin
      run_r <= 1'b0;
      gate_r <= 1'b0;
    end else begin
      run_r <= (state_nxt == CH_RUN); // see [RL1]
      gate_r <= (state_nxt == CH_RUN) && dim_on; // see [RL7]
    end
  end

  assign switch_run = run_r;
  assign disconnect_gate_drive = gate_r;
endmodule

// ---- hw/led_channel_fault_monitor.sv ----
/*
 Fault monitor for a two-channel LED driver: two channel units, one latched
 status register with enables, one open-drain active-low alert.
 Assumes the host interface turns its commands into the plain ports below.
*/
`timescale 1ns/10ps
module led_channel_fault_monitor (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Channel 1 comparator pins
  input wire logic ch1_feedback_overvoltage_fault_cmp,
  input wire logic ch1_fb_near_reg_cmp,
  input wire logic ch1_sense_low_cmp,
  input wire logic ch1_fb_short_cmp,
  // Channel 2 comparator pins
  input wire logic ch2_feedback_overvoltage_fault_cmp,
  input wire logic ch2_fb_near_reg_cmp,
  input wire logic ch2_sense_low_cmp,
  input wire logic ch2_fb_short_cmp,
  // Channel control
  input wire logic ch1_enable,
  input wire logic ch2_enable,
  input wire logic ch1_dim_on,
  input wire logic ch2_dim_on,
  // Host commands
  input wire logic status_clear,
  input wire fault_pkg::status_t status_clear_mask,
  input wire logic enable_write,
  input wire fault_pkg::status_t enable_wdata,
  // Power stage
  output logic ch1_switch_run,
  output logic ch2_switch_run,
  output logic ch1_disconnect_gate_drive,
  output logic ch2_disconnect_gate_drive,
  // Status and alert
  output fault_pkg::status_t status,
  output fault_pkg::status_t fault_report_enable,
  output logic alert_out,
  output logic alert_oe_n
);
  import fault_pkg::*;
  `include "fault_consts.svh"

  status_t status_r, status_nxt, set_vec;
  status_t enable_r, enable_nxt;
  logic alert_oe_n_r;
  logic ch1_ov, ch1_open, ch1_short;
  logic ch2_ov, ch2_open, ch2_short;
  logic ch1_halt, ch2_halt;

  // Latched stop bits hold each channel off until cleared
  assign ch1_halt = status_r[`CH1_FEEDBACK_OVERVOLTAGE_FAULT_BIT] | status_r[`CH1_SHORT_BIT];
  assign ch2_halt = status_r[`CH2_FEEDBACK_OVERVOLTAGE_FAULT_BIT] | status_r[`CH2_SHORT_BIT];

  // Independent units, one per channel, sharing status and alert
  channel_fault_unit u_ch1 ( // see [RL11]
    .clk(clk),
    .rst(rst),
    .feedback_overvoltage_fault_cmp(ch1_feedback_overvoltage_fault_cmp),
    .fb_near_reg_cmp(ch1_fb_near_reg_cmp),
    .sense_low_cmp(ch1_sense_low_cmp),
    .fb_short_cmp(ch1_fb_short_cmp),
    .channel_enable(ch1_enable),
    .dim_on(ch1_dim_on),
    .halt_latched(ch1_halt),
    .ov_fault(ch1_ov),
    .open_fault(ch1_open),
    .short_fault(ch1_short),
    .switch_run(ch1_switch_run),
    .disconnect_gate_drive(ch1_disconnect_gate_drive)
  );

  channel_fault_unit u_ch2 ( // see [RL11]
    .clk(clk),
    .rst(rst),
    .feedback_overvoltage_fault_cmp(ch2_feedback_overvoltage_fault_cmp),
    .fb_near_reg_cmp(ch2_fb_near_reg_cmp),
    .sense_low_cmp(ch2_sense_low_cmp),
    .fb_short_cmp(ch2_fb_short_cmp),
    .channel_enable(ch2_enable),
    .dim_on(ch2_dim_on),
    .halt_latched(ch2_halt),
    .ov_fault(ch2_ov),
    .open_fault(ch2_open),
    .short_fault(ch2_short),
    .switch_run(ch2_switch_run),
    .disconnect_gate_drive(ch2_disconnect_gate_drive)
  );

  always_comb begin
    set_vec = '0;
    set_vec[`CH1_FEEDBACK_OVERVOLTAGE_FAULT_BIT] = ch1_ov; // see [RL2]
    set_vec[`CH2_FEEDBACK_OVERVOLTAGE_FAULT_BIT] = ch2_ov; // see [RL2]
    set_vec[`CH1_OPEN_BIT] = ch1_open; // see [RL5]
    set_vec[`CH2_OPEN_BIT] = ch2_open; // see [RL5]
    set_vec[`CH1_SHORT_BIT] = ch1_short; // see [RL6]
    set_vec[`CH2_SHORT_BIT] = ch2_short; // see [RL6]
  end

  // Set beats clear, so a fault in the clearing cycle is kept
  always_comb begin
    status_nxt = status_r;
    if (status_clear) begin
      status_nxt = status_r & ~status_clear_mask; // see [RL8]
    end
    status_nxt = status_nxt | set_vec; // see [RL8]
  end

  always_comb begin
    enable_nxt = enable_r;
    if (enable_write) begin
      enable_nxt = enable_wdata;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      status_r <= `STATUS_RESET;
    end else begin
      status_r <= status_nxt;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      enable_r <= `ENABLE_RESET; // see [RL9]
    end else begin
      enable_r <= enable_nxt;
    end
  end

  // Built from next values so the pin falls at the edge that sets the bit
  always_ff @(posedge clk) begin
    if (rst) begin
      alert_oe_n_r <= 1'b1;
    end else begin
      alert_oe_n_r <= ~|(status_nxt & enable_nxt); // see [RL3] see [RL9] see [RL10]
    end
  end

  assign status = status_r;
  assign fault_report_enable = enable_r;
  // Open drain: only ever drives low, released means not asserted
  assign alert_out = 1'b0; // see [RL10]
  assign alert_oe_n = alert_oe_n_r;
endmodule

// ---- tb/fault_monitor_props.sv ----
/* Port checker for the LED fault monitor.
 Assumes one clock and a bind onto the top module. */
`timescale 1ns/10ps
module fault_monitor_props (
  input wire logic clk,
  input wire logic rst,
  input wire logic ch1_feedback_overvoltage_fault_cmp,
  input wire logic ch2_feedback_overvoltage_fault_cmp,
  input wire logic ch1_fb_near_reg_cmp,
  input wire logic ch1_sense_low_cmp,
  input wire logic ch2_fb_short_cmp,
  input wire logic ch1_switch_run,
  input wire logic ch2_switch_run,
  input wire logic ch1_disconnect_gate_drive,
  input wire logic status_clear,
  input wire fault_pkg::status_t status_clear_mask,
  input wire logic enable_write,
  input wire fault_pkg::status_t enable_wdata,
  input wire fault_pkg::status_t status,
  input wire fault_pkg::status_t fault_report_enable,
  input wire logic alert_out,
  input wire logic alert_oe_n
);
  import fault_pkg::*;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  chk_ov1_sets_bit: assert property (ch1_feedback_overvoltage_fault_cmp [*6] |=> status[4])
    else $error("ch1 overvoltage bit not set");
  chk_ov2_sets_bit: assert property (
    ch2_feedback_overvoltage_fault_cmp [*6] |=> status[0] && !ch2_switch_run)
    else $error("ch2 overvoltage not handled");
  chk_ov_halts_switch: assert property (
    status[4] |-> !ch1_switch_run && !ch1_disconnect_gate_drive)
    else $error("ch1 still switching after overvoltage");
  chk_open_sets_bit: assert property (
    (ch1_fb_near_reg_cmp && ch1_sense_low_cmp) [*6] |=> status[5])
    else $error("ch1 open string bit not set");
  chk_short_sets_bit: assert property (
    (ch2_fb_short_cmp && ch2_switch_run) [*4] ##1 ch2_fb_short_cmp [*2] |=> status[2])
    else $error("ch2 short bit not set");
  chk_alert_follows_status: assert property (
    alert_oe_n == !(|(status & fault_report_enable)))
    else $error("alert does not match enabled status");
  chk_status_latch_hold: assert property (
    (($past(status) & ~status) &
    ~($past(status_clear) ? $past(status_clear_mask) : 8'h00)) == 8'h00)
    else $error("status bit dropped without clear");
  chk_enable_write_load: assert property (
    enable_write |=> fault_report_enable == $past(enable_wdata))
    else $error("enable write not loaded");
  chk_alert_drives_low: assert property (alert_out == 1'b0)
    else $error("alert data not low");
  cover property (status[4]);
  cover property (status[2]);
  cover property (!alert_oe_n);
  cover property (status[5] && alert_oe_n);
endmodule
bind led_channel_fault_monitor fault_monitor_props chk (
  .clk(clk),
  .rst(rst),
  .ch1_feedback_overvoltage_fault_cmp(ch1_feedback_overvoltage_fault_cmp),
  .ch2_feedback_overvoltage_fault_cmp(ch2_feedback_overvoltage_fault_cmp),
  .ch1_fb_near_reg_cmp(ch1_fb_near_reg_cmp),
  .ch1_sense_low_cmp(ch1_sense_low_cmp),
  .ch2_fb_short_cmp(ch2_fb_short_cmp),
  .ch1_switch_run(ch1_switch_run),
  .ch2_switch_run(ch2_switch_run),
  .ch1_disconnect_gate_drive(ch1_disconnect_gate_drive),
  .status_clear(status_clear),
  .status_clear_mask(status_clear_mask),
  .enable_write(enable_write),
  .enable_wdata(enable_wdata),
  .status(status),
  .fault_report_enable(fault_report_enable),
  .alert_out(alert_out),
  .alert_oe_n(alert_oe_n)
);

// ---- tb/host_model.sv ----
/* Host model: clear and enable commands as one-cycle pulses.
 Assumes the bench calls cmd; drives just after the rising edge. */
`timescale 1ns/10ps
module host_model (
  input wire logic clk,
  output logic status_clear,
  output fault_pkg::status_t status_clear_mask,
  output logic enable_write,
  output fault_pkg::status_t enable_wdata
);
  import fault_pkg::*;
  initial begin
    status_clear = 1'b0;
    enable_write = 1'b0;
    status_clear_mask = 8'h00;
    enable_wdata = 8'hFF;
  end
  // Idle data lines show the inverse, so stale values never pass
  task cmd(input logic clr, input status_t v);
    @(posedge clk) #1;
    status_clear = clr;
    enable_write = !clr;
    status_clear_mask = v;
    enable_wdata = v;
    @(posedge clk) #1;
    status_clear = 1'b0;
    enable_write = 1'b0;
    status_clear_mask = ~v;
    enable_wdata = ~v;
  endtask
endmodule

// ---- tb/led_channel_fault_monitor_tb.sv ----
/* Bench for the LED fault monitor: comparator pins and channel controls.
 Assumes host_model for commands and a pull-up on the alert line. */
`timescale 1ns/10ps
module led_channel_fault_monitor_tb;
  import fault_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [3:0] c1 = 4'h0;
  logic [3:0] c2 = 4'h0;
  logic [1:0] dim = 2'b11;
  logic [1:0] ena = 2'b11;
  logic sc, ew, r1, r2, g1, g2, ao, aoe;
  status_t scm, ewd, st, en;
  int n_errors = 0;
  int checked = 0;
  wire alert_line = aoe ? 1'b1 : ao;
  always #10 clk = ~clk;
  host_model host (.clk(clk), .status_clear(sc), .status_clear_mask(scm),
    .enable_write(ew), .enable_wdata(ewd));
  led_channel_fault_monitor uut (.clk(clk), .rst(rst),
    .ch1_feedback_overvoltage_fault_cmp(c1[0]), .ch1_fb_near_reg_cmp(c1[1]), .ch1_sense_low_cmp(c1[2]),
    .ch1_fb_short_cmp(c1[3]), .ch2_feedback_overvoltage_fault_cmp(c2[0]), .ch2_fb_near_reg_cmp(c2[1]),
    .ch2_sense_low_cmp(c2[2]), .ch2_fb_short_cmp(c2[3]), .ch1_enable(ena[0]),
    .ch2_enable(ena[1]), .ch1_dim_on(dim[0]), .ch2_dim_on(dim[1]), .status_clear(sc),
    .status_clear_mask(scm), .enable_write(ew), .enable_wdata(ewd),
    .ch1_switch_run(r1), .ch2_switch_run(r2), .ch1_disconnect_gate_drive(g1),
    .ch2_disconnect_gate_drive(g2), .status(st), .fault_report_enable(en),
    .alert_out(ao), .alert_oe_n(aoe));
  task tk(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task chk(input string n, input logic [7:0] e, input logic [7:0] g);
    checked++;
    if (g !== e) begin
      $display("MISMATCH %s expected %h seen %h", n, e, g);
      n_errors++;
    end
  endtask
  task close_out;
    $display("checks %0d mismatches %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task t_overvoltage;
    c1[0] = 1'b1;
    tk(6);
    chk("status", 8'h10, st);
    chk("run_gate1", 8'h00, {6'h0, r1, g1});
    chk("alert", 8'h00, 8'(alert_line));
    c1[0] = 1'b0;
    tk(4);
    chk("status", 8'h10, st);
    host.cmd(1'b1, 8'h10);
    tk(6);
    chk("status", 8'h00, st);
    chk("run_gate1", 8'h03, {6'h0, r1, g1});
    c2[0] = 1'b1;
    tk(6);
    chk("status", 8'h01, st);
    chk("run_gate2", 8'h00, {6'h0, r2, g2});
    chk("run1", 8'h01, 8'(r1));
    host.cmd(1'b1, 8'h01);
    tk(2);
    chk("status", 8'h01, st);
    c2[0] = 1'b0;
    tk(4);
    host.cmd(1'b1, 8'h01);
    tk(2);
    chk("alert", 8'h01, 8'(alert_line));
    $display("overvoltage test done");
  endtask
  task t_open_masked;
    host.cmd(1'b0, 8'hDF);
    c1[2:1] = 2'b11;
    tk(6);
    chk("status", 8'h20, st);
    chk("alert", 8'h01, 8'(alert_line));
    host.cmd(1'b0, 8'hFF);
    chk("alert", 8'h00, 8'(alert_line));
    c1[2:1] = 2'b00;
    tk(4);
    host.cmd(1'b1, 8'h20);
    tk(2);
    chk("status", 8'h00, st);
    $display("open string test done");
  endtask
  task t_short;
    dim[1] = 1'b0;
    tk(3);
    chk("run_gate2", 8'h02, {6'h0, r2, g2});
    ena[1] = 1'b0;
    tk(3);
    chk("run12", 8'h02, {6'h0, r1, r2});
    ena[1] = 1'b1;
    tk(3);
    chk("run_gate2", 8'h02, {6'h0, r2, g2});
    c2[3] = 1'b1;
    c1[3] = 1'b1;
    c2[2:1] = 2'b11;
    tk(6);
    chk("status", 8'h46, st);
    chk("run12", 8'h00, {6'h0, r1, r2});
    chk("alert", 8'h00, 8'(alert_line));
    c2[3] = 1'b0;
    c1[3] = 1'b0;
    c2[2:1] = 2'b00;
    tk(4);
    host.cmd(1'b1, 8'h46);
    tk(2);
    chk("status", 8'h00, st);
    $display("short string test done");
  endtask
  initial begin
    tk(8);
    rst = 1'b0;
    chk("status", 8'h00, st);
    chk("enable", 8'hFF, en);
    tk(4);
    t_overvoltage();
    t_open_masked();
    t_short();
    close_out();
  end
  initial begin
    repeat (5000) @(posedge clk);
    n_errors++;
    close_out();
  end
endmodule
